// ---- include/pcs_pkg.sv ----
// constants, types and carriers of the peak current pwm fault sequencer
package pcs_pkg;

	localparam int CLK_HZ = 100_000_000;
	localparam int CLK_NS = 10;

	// switching rates and their periods in clock cycles
	localparam int FIXED_HZ = 60_000;
	localparam int GREEN_HZ = 23_000;
	localparam logic [15:0] FIXED_CYC = 16'(CLK_HZ / FIXED_HZ);
	localparam logic [15:0] GREEN_CYC = 16'(CLK_HZ / GREEN_HZ);
	localparam logic [15:0] GREEN_STEP = 16'h0020;
	localparam logic [15:0] JITTER_MID = 16'h0010;

	// leading edge blanking, least time, rounded up
	localparam int BLANK_NS = 230;
	localparam logic [7:0] BLANK_CYC = 8'((BLANK_NS + CLK_NS - 1) / CLK_NS);

	// burst cycle, overload delay and soft start
	localparam int BURST_US = 740;
	localparam logic [16:0] BURST_CYC = 17'(BURST_US * 1000 / CLK_NS);
	localparam int OLP_MS = 72;
	localparam logic [22:0] OLP_CYC = 23'(OLP_MS * 1_000_000 / CLK_NS);
	localparam int SOFT_US = 5200;
	localparam logic [19:0] SOFT_CYC = 20'(SOFT_US * 1000 / CLK_NS);
	localparam logic [2:0] SOFT_STEPS = 3'h7;
	localparam logic [2:0] OCP_STEP_INIT = 3'h1;

	// random modulation generator
	localparam logic [15:0] LFSR_SEED = 16'hACE1;
	localparam logic [15:0] LFSR_TAPS = 16'hB400;

	typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_FAULT} pcs_state_t;
	typedef enum logic [1:0] {MODE_FIXED, MODE_GREEN, MODE_BURST} pcs_mode_t;

	// comparator results from the analog side
	typedef struct packed {
		logic peak_hit;
		logic ceiling_hit;
		logic fb_low;
		logic light_load;
		logic standby;
		logic vcc_on;
		logic vcc_undervoltage_lockout;
		logic vcc_ovp;
		logic vcc_low;
		logic tsd_hot;
		logic tsd_cool;
	} pcs_analog_t;

	typedef struct packed {
		pcs_mode_t mode;
		logic soft_start;
		logic running;
		logic overload;
		logic overvoltage;
		logic thermal;
	} pcs_status_t;

	localparam pcs_analog_t ANALOG_IDLE = '0;
	localparam pcs_status_t STATUS_IDLE = '0;

endpackage : pcs_pkg

// ---- logic/pcs_lfsr.sv ----
// pseudo random source for switching period modulation
module pcs_lfsr (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic step_in,
	output logic [15:0] value_out
);

	logic [15:0] value_q;
	logic [15:0] value_d;

	// galois shift, advanced once per switching period
	assign value_d = {1'b0, value_q[15:1]} ^
		(value_q[0] ? pcs_pkg::LFSR_TAPS : 16'h0000);

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			value_q <= pcs_pkg::LFSR_SEED;
		end else if (step_in) begin
			value_q <= value_d;
		end
	end

	assign value_out = value_q;

endmodule : pcs_lfsr

// ---- logic/pcs_top.sv ----
// switch control and fault sequencing of a peak current mode converter
// What this block does
// - switch turns off once sensed current reaches the feedback target
// - switch turns on again one average period after previous turn-on
// - current comparators ignored for 230 ns after each turn-on
// - switching period is randomly dithered around the mean rate
// - light load stretches period from 60 kHz toward 23 kHz, then bursts
// - burst operation starts when drain current drops to standby level
// - bursts repeat every 740 us, switching stopped between them
// - a burst may shrink to one single switching pulse
// - burst timer free runs, unsynchronised to the switching oscillator
// - switch turns off at the fixed drain current ceiling
// - feedback low for 72 ms continuously latches overload and stops
// - after overload stop, wait for lockout then restart, repeating
// - supply at overvoltage level stops switching
// - overvoltage repeats lockout restart cycle until it clears
// - over-temperature stops switching
// - while hot, startup current holds supply above lockout when low
// - once cooled, startup current stops, supply drops, normal restart
// - start at supply start level, full stop at supply stop level
// - soft start of 5.2 ms raises current threshold in 6 steps, from level 1 to 7
// - blanking disabled during soft start
// - feedback sampled once per pulse right after turn-off
module pcs_top #(
	parameter logic [15:0] P_GREEN_CYC = pcs_pkg::GREEN_CYC,
	parameter logic [16:0] P_BURST_CYC = pcs_pkg::BURST_CYC,
	parameter logic [22:0] P_OLP_CYC = pcs_pkg::OLP_CYC,
	parameter logic [19:0] P_SOFT_CYC = pcs_pkg::SOFT_CYC
) (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire pcs_pkg::pcs_analog_t analog_in,
	output logic gate_out,
	output logic startup_en_out,
	output logic fb_sample_out,
	output logic [2:0] ocp_step_out,
	output pcs_pkg::pcs_status_t status_out
);

	localparam logic [19:0] SOFT_STEP_CYC =
		20'(P_SOFT_CYC / {17'h00000, pcs_pkg::SOFT_STEPS});

	pcs_pkg::pcs_analog_t ana_m_q;
	pcs_pkg::pcs_analog_t ana;
	pcs_pkg::pcs_state_t state_q;
	pcs_pkg::pcs_state_t state_d;
	pcs_pkg::pcs_mode_t mode_q;
	pcs_pkg::pcs_mode_t mode_d;
	pcs_pkg::pcs_status_t status_q;
	pcs_pkg::pcs_status_t status_d;
	logic gate_q, gate_d;
	logic startup_q, startup_d;
	logic fb_sample_q;
	logic [15:0] per_cnt_q, per_cnt_d;
	logic [15:0] per_len_q, per_len_d;
	logic [15:0] cur_period_q, cur_period_d;
	logic [15:0] rnd;
	logic [7:0] blank_cnt_q, blank_cnt_d;
	logic [16:0] burst_cnt_q, burst_cnt_d;
	logic burst_open_q, burst_open_d;
	logic [22:0] olp_cnt_q, olp_cnt_d;
	logic [19:0] soft_cnt_q, soft_cnt_d;
	logic [19:0] step_cnt_q, step_cnt_d;
	logic [2:0] ocp_step_q, ocp_step_d;
	logic olp_q, ovp_q, tsd_q;
	logic [7:0] on_cnt_q;
	wire running;
	wire soft_active;
	wire blank_done;
	wire trip;
	wire per_wrap;
	wire half_reached;
	wire burst_tick;
	wire olp_hit;
	wire fault_now;
	wire turn_on;
	wire turn_off;
	wire to_fault;
	wire to_run;

	// moves the period one step toward a bound, saturating there
	function automatic logic [15:0] step_toward(input logic [15:0] cur,
		input logic up, input logic [15:0] lo, input logic [15:0] hi);
		logic [16:0] sum;
		logic [16:0] dif;
		sum = {1'b0, cur} + {1'b0, pcs_pkg::GREEN_STEP};
		dif = {1'b0, cur} - {1'b0, pcs_pkg::GREEN_STEP};
		if (up) begin
			step_toward = (sum[16] || sum[15:0] > hi) ? hi : sum[15:0];
		end else begin
			step_toward = (dif[16] || dif[15:0] < lo) ? lo : dif[15:0];
		end
	endfunction : step_toward

	// two flop synchroniser for all comparator results
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			ana_m_q <= pcs_pkg::ANALOG_IDLE;
			ana <= pcs_pkg::ANALOG_IDLE;
		end else begin
			ana_m_q <= analog_in;
			ana <= ana_m_q;
		end
	end

	pcs_lfsr u_lfsr (
		.core_clk_in(core_clk_in),
		.rst_n_in(rst_n_in),
		.step_in(per_wrap),
		.value_out(rnd)
	);

	assign running = state_q == pcs_pkg::ST_RUN;
	assign soft_active = running && soft_cnt_q < P_SOFT_CYC;
	assign blank_done = soft_active || blank_cnt_q == pcs_pkg::BLANK_CYC;
	assign trip = blank_done && (ana.peak_hit || ana.ceiling_hit);
	assign per_wrap = per_cnt_q + 16'h0001 == per_len_q;
	assign half_reached = per_cnt_q >= {1'b0, per_len_q[15:1]};
	assign burst_tick = burst_cnt_q == P_BURST_CYC - 17'h00001;
	assign olp_hit = olp_cnt_q == P_OLP_CYC;
	assign fault_now = ana.vcc_ovp || ana.tsd_hot || olp_hit;
	assign to_fault = running && !ana.vcc_undervoltage_lockout && fault_now;
	assign to_run = state_q == pcs_pkg::ST_IDLE && state_d == pcs_pkg::ST_RUN;

	// turn on at each period end, gated by burst window
	assign turn_on = per_wrap && running && !fault_now && !ana.vcc_undervoltage_lockout &&
		!gate_q && (mode_q != pcs_pkg::MODE_BURST || burst_open_q);
	// half period cap keeps on-duty at most one half
	assign turn_off = gate_q && (trip || half_reached || !running ||
		fault_now || ana.vcc_undervoltage_lockout);
	assign gate_d = turn_off ? 1'b0 : (turn_on ? 1'b1 : gate_q);

	// free running oscillator with dithered period
	assign per_cnt_d = per_wrap ? 16'h0000 : per_cnt_q + 16'h0001;
	assign per_len_d = per_wrap ?
		cur_period_q + {11'h000, rnd[4:0]} - pcs_pkg::JITTER_MID :
		per_len_q;
	assign cur_period_d = !running ? pcs_pkg::FIXED_CYC :
		(per_wrap ? step_toward(cur_period_q, ana.light_load,
		pcs_pkg::FIXED_CYC, P_GREEN_CYC) : cur_period_q);

	// burst cycle timer, independent of the period counter
	assign burst_cnt_d = burst_tick ? 17'h00000 : burst_cnt_q + 17'h00001;
	// window opens each cycle, closes after a pulse still at standby
	assign burst_open_d = burst_tick ? 1'b1 :
		((turn_off && ana.standby && mode_q == pcs_pkg::MODE_BURST) ?
		1'b0 : burst_open_q);
	// no burst during soft start
	assign mode_d = (running && ana.standby && !soft_active) ?
		pcs_pkg::MODE_BURST : (cur_period_q != pcs_pkg::FIXED_CYC ?
		pcs_pkg::MODE_GREEN : pcs_pkg::MODE_FIXED);

	assign blank_cnt_d = turn_on ? 8'h00 :
		((gate_q && blank_cnt_q < pcs_pkg::BLANK_CYC) ?
		blank_cnt_q + 8'h01 : blank_cnt_q);

	assign olp_cnt_d = !(running && ana.fb_low) ? 23'h000000 :
		(olp_hit ? olp_cnt_q : olp_cnt_q + 23'h000001);

	// soft start time and threshold staircase
	assign soft_cnt_d = !running ? 20'h00000 :
		(soft_active ? soft_cnt_q + 20'h00001 : soft_cnt_q);
	assign step_cnt_d = (!soft_active ||
		step_cnt_q == SOFT_STEP_CYC - 20'h00001) ?
		20'h00000 : step_cnt_q + 20'h00001;
	assign ocp_step_d = !running ? pcs_pkg::OCP_STEP_INIT :
		(!soft_active ? pcs_pkg::SOFT_STEPS :
		((step_cnt_q == SOFT_STEP_CYC - 20'h00001 &&
		ocp_step_q < pcs_pkg::SOFT_STEPS) ?
		ocp_step_q + 3'h1 : ocp_step_q));

	// startup current: always before start, held while hot in fault
	assign startup_d = state_q == pcs_pkg::ST_IDLE ? 1'b1 :
		((state_q == pcs_pkg::ST_FAULT && tsd_q && !ana.tsd_cool) ?
		(ana.vcc_low || (startup_q && !ana.vcc_on)) : 1'b0);

	assign status_d = '{mode: mode_d, soft_start: soft_active,
		running: running, overload: olp_q, overvoltage: ovp_q,
		thermal: tsd_q};

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			pcs_pkg::ST_IDLE: begin
				if (ana.vcc_on && !ana.vcc_undervoltage_lockout) state_d = pcs_pkg::ST_RUN;
			end
			pcs_pkg::ST_RUN: begin
				if (ana.vcc_undervoltage_lockout) state_d = pcs_pkg::ST_IDLE;
				else if (fault_now) state_d = pcs_pkg::ST_FAULT;
			end
			pcs_pkg::ST_FAULT: begin
				if (ana.vcc_undervoltage_lockout) state_d = pcs_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			state_q <= pcs_pkg::ST_IDLE;
			mode_q <= pcs_pkg::MODE_FIXED;
			gate_q <= 1'b0;
			startup_q <= 1'b0;
			fb_sample_q <= 1'b0;
			status_q <= pcs_pkg::STATUS_IDLE;
		end else begin
			state_q <= state_d;
			mode_q <= mode_d;
			gate_q <= gate_d;
			startup_q <= startup_d;
			fb_sample_q <= turn_off;
			status_q <= status_d;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			per_cnt_q <= 16'h0000;
			per_len_q <= pcs_pkg::FIXED_CYC;
			cur_period_q <= pcs_pkg::FIXED_CYC;
			blank_cnt_q <= 8'h00;
			burst_cnt_q <= 17'h00000;
			burst_open_q <= 1'b0;
		end else begin
			per_cnt_q <= per_cnt_d;
			per_len_q <= per_len_d;
			cur_period_q <= cur_period_d;
			blank_cnt_q <= blank_cnt_d;
			burst_cnt_q <= burst_cnt_d;
			burst_open_q <= burst_open_d;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			olp_cnt_q <= 23'h000000;
			soft_cnt_q <= 20'h00000;
			step_cnt_q <= 20'h00000;
			ocp_step_q <= pcs_pkg::OCP_STEP_INIT;
		end else begin
			olp_cnt_q <= olp_cnt_d;
			soft_cnt_q <= soft_cnt_d;
			step_cnt_q <= step_cnt_d;
			ocp_step_q <= ocp_step_d;
		end
	end

	// fault cause kept until the next start
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in || to_run) begin
			olp_q <= 1'b0;
			ovp_q <= 1'b0;
			tsd_q <= 1'b0;
		end else if (to_fault) begin
			olp_q <= olp_hit;
			ovp_q <= ana.vcc_ovp;
			tsd_q <= ana.tsd_hot;
		end
	end

	// on-time length, read only by the checks below
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in || !gate_q) begin
			on_cnt_q <= 8'h00;
		end else if (on_cnt_q != 8'hFF) begin
			on_cnt_q <= on_cnt_q + 8'h01;
		end
	end

	assign gate_out = gate_q;
	assign startup_en_out = startup_q;
	assign fb_sample_out = fb_sample_q;
	assign ocp_step_out = ocp_step_q;
	assign status_out = status_q;

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);

	a_peak_turn_off: assert property (
		gate_q && running && blank_done && ana.peak_hit |=> !gate_q)
		else $error("switch stayed on past peak target");
	a_ceiling_off: assert property (
		gate_q && blank_done && ana.ceiling_hit |=> !gate_q)
		else $error("switch stayed on past current ceiling");
	a_period_turn_on: assert property (
		$rose(gate_q) |-> per_cnt_q == 16'h0000 && $past(running))
		else $error("turn-on not at period start");
	a_period_bounds: assert property (
		per_len_q >= pcs_pkg::FIXED_CYC - pcs_pkg::JITTER_MID &&
		per_len_q < P_GREEN_CYC + pcs_pkg::JITTER_MID)
		else $error("switching period out of range");
	a_blank_length: assert property (
		$fell(gate_q) && $past(!soft_active && running && !fault_now &&
		!ana.vcc_undervoltage_lockout) |-> $past(on_cnt_q) >= pcs_pkg::BLANK_CYC)
		else $error("pulse ended inside blanking time");
	a_burst_hold: assert property (
		mode_q == pcs_pkg::MODE_BURST && !burst_open_q |=> !$rose(gate_q))
		else $error("pulse outside burst window");
	a_burst_open: assert property (
		burst_tick |=> burst_open_q ##1 !burst_tick [*8])
		else $error("burst timer did not open window");
	a_overload_stop: assert property (
		running && olp_hit && !ana.vcc_undervoltage_lockout |=>
		state_q == pcs_pkg::ST_FAULT && !gate_q && olp_q)
		else $error("overload did not stop switching");
	a_ovp_stop: assert property (
		running && ana.vcc_ovp |=> !gate_q && state_q != pcs_pkg::ST_RUN)
		else $error("overvoltage did not stop switching");
	a_thermal_hold: assert property (
		state_q == pcs_pkg::ST_FAULT && tsd_q && !ana.tsd_cool &&
		ana.vcc_low |=> startup_q)
		else $error("no startup current while hot");
	a_thermal_release: assert property (
		state_q == pcs_pkg::ST_FAULT && ana.tsd_cool |=> !startup_q)
		else $error("startup current kept after cooling");
	a_undervoltage_lockout_stop: assert property (
		ana.vcc_undervoltage_lockout |=> state_q == pcs_pkg::ST_IDLE && !gate_q)
		else $error("lockout did not stop control");
	a_soft_final: assert property (
		running && !soft_active && $past(running) |->
		ocp_step_q == pcs_pkg::SOFT_STEPS)
		else $error("threshold not at last step after soft start");
	a_fb_sample: assert property (
		$fell(gate_q) |-> fb_sample_q ##1 !fb_sample_q)
		else $error("feedback not sampled at turn-off");

endmodule : pcs_top

// ---- test/pcs_stage_model.sv ----
// power stage stand-in: sensed current ramps while the switch is on
module pcs_stage_model (
	input wire logic core_clk_in,
	input wire logic gate_in,
	input wire logic [15:0] peak_dly_in,
	input wire logic [15:0] ceil_dly_in,
	output logic peak_hit_out = 1'b0,
	output logic ceiling_hit_out = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] on_q = 16'h0000;
	// current collapses as soon as the switch opens; zero delay disables
	always @(posedge core_clk_in) begin
		on_q <= gate_in ? on_q + 16'h0001 : 16'h0000;
		peak_hit_out <= gate_in && peak_dly_in != 16'h0000 && on_q >= peak_dly_in;
		ceiling_hit_out <= gate_in && ceil_dly_in != 16'h0000 && on_q >= ceil_dly_in;
	end
endmodule : pcs_stage_model

// ---- test/tb.sv ----
// self-checking bench of the peak current pwm fault sequencer
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	pcs_pkg::pcs_analog_t ana = pcs_pkg::ANALOG_IDLE;
	pcs_pkg::pcs_analog_t ana_mix;
	pcs_pkg::pcs_status_t stat;
	logic peak, ceil, gate, st_en, fb_smp;
	logic g_d = 1'b0;
	logic [2:0] overcurrent_trip;
	logic [2:0] ocp_d = 3'h1;
	logic [15:0] pk_dly = 16'h0000;
	logic [15:0] cl_dly = 16'h0000;
	int err_count = 0, checks_done = 0, cyc_n = 0, t_rise = 0;
	int rises = 0, on_cnt = 0, last_on = 0, last_per = 0, steps = 0;

	always #5 clk = ~clk;

	always_comb begin
		ana_mix = ana;
		ana_mix.peak_hit = peak;
		ana_mix.ceiling_hit = ceil;
	end

	pcs_top #(.P_GREEN_CYC(16'h07D0), .P_BURST_CYC(17'h01388),
		.P_OLP_CYC(23'h0000C8), .P_SOFT_CYC(20'h00DAC)) u_dut (
		.core_clk_in(clk), .rst_n_in(rst_n), .analog_in(ana_mix),
		.gate_out(gate), .startup_en_out(st_en), .fb_sample_out(fb_smp),
		.ocp_step_out(overcurrent_trip), .status_out(stat));

	pcs_stage_model u_stage (.core_clk_in(clk), .gate_in(gate),
		.peak_dly_in(pk_dly), .ceil_dly_in(cl_dly),
		.peak_hit_out(peak), .ceiling_hit_out(ceil));

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask : chk

	task automatic rng(input string nm, input int v, lo, hi);
		chk(nm, 32'(v >= lo && v <= hi), 32'h1);
	endtask : rng

	// pulse timing watcher
	always @(posedge clk) begin
		if (gate && !g_d) begin
			last_per = cyc_n - t_rise;
			t_rise = cyc_n;
			rises++;
			on_cnt = 0;
		end
		if (gate) on_cnt++;
		if (g_d && !gate) begin
			last_on = on_cnt;
			if (stat.running && !ana.fb_low && ana[4:0] == 5'h00)
				chk("fb sample", fb_smp, 1'b1);
		end
		if (overcurrent_trip !== ocp_d) steps++;
		ocp_d = overcurrent_trip;
		g_d = gate;
		cyc_n++;
	end

	task automatic tick(input int n);
		repeat (n) begin
			@(posedge clk);
			#1;
		end
	endtask : tick

	task automatic complete_run();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : complete_run

	task automatic pulse(output int on, per);
		int r0;
		r0 = rises;
		for (int i = 0; i < 6000 && rises == r0; i++) tick(1);
		for (int i = 0; i < 2000 && gate; i++) tick(1);
		// watcher logs the on-time one edge after the fall
		tick(1);
		if (rises == r0 || gate) begin
			chk("pulse wait", 32'h0, 32'h1);
			complete_run();
		end
		on = last_on;
		per = last_per;
	endtask : pulse

	task automatic t_reset();
		tick(5);
		chk("gate rst", gate, 1'b0);
		chk("startup rst", st_en, 1'b0);
		chk("ocp rst", overcurrent_trip, 3'h1);
		chk("status rst", stat, pcs_pkg::STATUS_IDLE);
		rst_n = 1'b1;
		tick(3);
		chk("startup idle", st_en, 1'b1);
	endtask : t_reset

	task automatic t_start();
		int on, per, s0;
		pk_dly = 16'h0005;
		ana.vcc_undervoltage_lockout = 1'b0;
		ana.vcc_on = 1'b1;
		tick(6);
		s0 = steps;
		chk("running", stat.running, 1'b1);
		chk("startup off", st_en, 1'b0);
		chk("soft", stat.soft_start, 1'b1);
		chk("ocp first", overcurrent_trip, 3'h1);
		pulse(on, per);
		rng("soft on time", on, 4, 12);
		tick(3600);
		chk("ocp full", overcurrent_trip, 3'h7);
		chk("ocp steps", steps - s0, 32'h6);
		chk("soft end", stat.soft_start, 1'b0);
	endtask : t_start

	task automatic restart();
		ana.vcc_on = 1'b0;
		ana.vcc_undervoltage_lockout = 1'b1;
		tick(6);
		chk("lockout", st_en, 1'b1);
		chk("lockout stop", stat.running, 1'b0);
	endtask : restart

	task automatic t_pwm();
		int on, per, p0;
		logic same;
		same = 1'b1;
		pulse(on, per);
		rng("blank on time", on, 24, 28);
		pk_dly = 16'h003C;
		pulse(on, p0);
		for (int i = 0; i < 4; i++) begin
			pulse(on, per);
			rng("peak on time", on, 60, 66);
			rng("period", per, 1650, 1681);
			if (per != p0) same = 1'b0;
		end
		chk("dither", same, 1'b0);
		pk_dly = 16'h0000;
		cl_dly = 16'h0028;
		pulse(on, per);
		rng("ceiling on time", on, 40, 46);
		chk("mode fixed", stat.mode, pcs_pkg::MODE_FIXED);
		cl_dly = 16'h0000;
		pk_dly = 16'h003C;
	endtask : t_pwm

	task automatic t_green();
		int on, per, r0;
		ana.light_load = 1'b1;
		repeat (6) pulse(on, per);
		chk("mode green", stat.mode, pcs_pkg::MODE_GREEN);
		rng("green period", per, 1682, 2015);
		ana.light_load = 1'b0;
		repeat (9) pulse(on, per);
		chk("mode back", stat.mode, pcs_pkg::MODE_FIXED);
		ana.standby = 1'b1;
		tick(10);
		chk("mode burst", stat.mode, pcs_pkg::MODE_BURST);
		r0 = rises;
		tick(15000);
		rng("burst pulses", rises - r0, 2, 4);
		ana.standby = 1'b0;
	endtask : t_green

	task automatic overload_delay();
		int r0;
		ana.fb_low = 1'b1;
		tick(150);
		ana.fb_low = 1'b0;
		tick(1);
		ana.fb_low = 1'b1;
		tick(150);
		chk("olp early", stat.overload, 1'b0);
		tick(70);
		chk("olp", stat.overload, 1'b1);
		r0 = rises;
		tick(2000);
		chk("olp stop", rises - r0, 32'h0);
		ana.fb_low = 1'b0;
		restart();
		t_start();
		chk("olp clear", stat.overload, 1'b0);
	endtask : overload_delay

	task automatic t_ovp();
		ana.vcc_ovp = 1'b1;
		tick(8);
		chk("ovp", stat.overvoltage, 1'b1);
		chk("ovp gate", gate, 1'b0);
		restart();
		ana.vcc_undervoltage_lockout = 1'b0;
		ana.vcc_on = 1'b1;
		tick(8);
		chk("ovp again", stat.overvoltage, 1'b1);
		chk("ovp again gate", gate, 1'b0);
		ana.vcc_ovp = 1'b0;
		restart();
		t_start();
		chk("ovp clear", stat.overvoltage, 1'b0);
	endtask : t_ovp

	task automatic t_tsd();
		ana.tsd_hot = 1'b1;
		tick(6);
		chk("tsd", stat.thermal, 1'b1);
		chk("tsd gate", gate, 1'b0);
		chk("tsd no start", st_en, 1'b0);
		ana.vcc_on = 1'b0;
		ana.vcc_low = 1'b1;
		tick(6);
		chk("tsd hold", st_en, 1'b1);
		ana.vcc_low = 1'b0;
		ana.tsd_hot = 1'b0;
		ana.tsd_cool = 1'b1;
		tick(6);
		chk("tsd release", st_en, 1'b0);
		restart();
		ana.tsd_cool = 1'b0;
		t_start();
		chk("tsd clear", stat.thermal, 1'b0);
	endtask : t_tsd

	initial begin
		t_reset();
		t_start();
		t_pwm();
		t_green();
		overload_delay();
		t_ovp();
		t_tsd();
		complete_run();
	end
endmodule : tb
